// ==== src/pldmc_pkg.sv ====
// constants, types and helpers of the programmable logic macrocell core
// assumes a 200 MHz ref_clk and a 32-bit Avalon-MM register bus
package pldmc_pkg;
  localparam int N_CELL = 8;
  localparam int N_DED = 11;
  localparam int N_IN = 19;
  localparam int N_TERM = 64;
  localparam int TERM_W = 38;
  localparam int PT_CELL = 8;
  localparam int SIG_W = 64;
  // register byte offsets
  localparam logic [5:0] ADR_CTRL = 6'h00;
  localparam logic [5:0] ADR_CELL = 6'h04;
  localparam logic [5:0] ADR_PRELOAD = 6'h08;
  localparam logic [5:0] ADR_STATUS = 6'h0C;
  localparam logic [5:0] ADR_SIG_LO = 6'h10;
  localparam logic [5:0] ADR_SIG_HI = 6'h14;
  localparam logic [5:0] ADR_CSUM = 6'h18;
  localparam logic [5:0] ADR_ARR_IDX = 6'h1C;
  localparam logic [5:0] ADR_ARR_DATA = 6'h20;
  // field positions
  localparam int CTRL_MODE_A = 0;
  localparam int CTRL_MODE_B = 1;
  localparam int CTRL_SECURE = 2;
  localparam int CTRL_PROGRAM = 3;
  localparam int ST_SECURE = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_PDOWN = 4;
  localparam int ST_READY = 5;
  localparam int DED_CLK = 0;
  localparam int DED_OE = 1;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [37:0] ERASED_TERM = 38'h3F_FFFF_FFFF;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_PWRUP_NS = 1000;
  localparam int PWRUP_CYC = T_PWRUP_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PWRUP_CNT = 8'(PWRUP_CYC);
  localparam logic [1:0] ARR_STALE = 2'h2;

  typedef enum logic [1:0] {
    MODE_SIMPLE, MODE_COMPLEX, MODE_REGISTERED, MODE_RESERVED
  } pldmc_mode_e;

  typedef enum logic {ER_IDLE, ER_RUN} pldmc_er_e;

  function automatic pldmc_mode_e pldmc_mode_of(input logic a,
                                                input logic b);
    case ({b, a})
      2'b00: return MODE_SIMPLE;
      2'b01: return MODE_COMPLEX;
      2'b10: return MODE_REGISTERED;
      default: return MODE_RESERVED;
    endcase
  endfunction : pldmc_mode_of

  function automatic logic [31:0] pldmc_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : pldmc_merge
endpackage : pldmc_pkg

// ==== src/pldmc_arr_if.sv ====
// link between the macrocell control logic and the AND-array store
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface pldmc_arr_if;
  logic wr;
  logic erase;
  logic busy;
  logic [6:0] idx;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic [18:0] in_vec;
  logic [63:0] pt;
  logic [37:0] acc;
  modport ctl (output wr, erase, idx, wr_data, in_vec,
               input busy, rd_data, pt, acc);
  modport mem (input wr, erase, idx, wr_data, in_vec,
               output busy, rd_data, pt, acc);
endinterface : pldmc_arr_if

// ==== src/pldmc_array.sv ====
// AND-array fuse store: 64 product terms of 38 fuses, registered terms
// assumes idx bit 0 picks the low word or the high 6 fuses of a term
`timescale 1ns/100ps
module pldmc_array
  import pldmc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control side
  pldmc_arr_if.mem a
);
  logic [TERM_W-1:0] fuse [N_TERM];
  pldmc_er_e er_st, next_er_st;
  logic [5:0] er_cnt, next_er_cnt;
  logic [31:0] next_rd;
  logic [63:0] next_pt;
  logic [TERM_W-1:0] next_acc, old_w, new_w;

  always_comb begin
    old_w = fuse[a.idx[6:1]];
    new_w = a.idx[0] ? {a.wr_data[5:0], old_w[31:0]}
                     : {old_w[37:32], a.wr_data};
    next_er_st = er_st;
    next_er_cnt = er_cnt;
    next_acc = a.acc;
    next_rd = a.idx[0] ? {26'h000_0000, old_w[37:32]} : old_w[31:0];
    next_pt = '0;
    case (er_st)
      ER_RUN: begin
        next_er_cnt = 6'(er_cnt + 6'h01);
        // all-ones terms fold to zero, so the sum restarts clean
        next_acc = '0;
        if (er_cnt == 6'h3F) begin
          next_er_st = ER_IDLE;
        end
      end
      ER_IDLE: begin
        if (a.erase) begin
          next_er_st = ER_RUN;
          next_er_cnt = 6'h00;
        end else if (a.wr) begin
          next_acc = a.acc ^ old_w ^ new_w;
        end
        for (int t = 0; t < N_TERM; t++) begin
          next_pt[t] = &((~fuse[t][N_IN-1:0] | a.in_vec) &
                         (~fuse[t][TERM_W-1:N_IN] | ~a.in_vec));
        end
      end
      default: next_er_st = ER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (er_st == ER_RUN) begin
      fuse[er_cnt] <= ERASED_TERM;
    end else if (a.wr && !a.erase) begin
      fuse[a.idx[6:1]] <= new_w;
    end
  end

  // power-up starts with a full erase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      er_st <= ER_RUN;
      er_cnt <= 6'h00;
      a.acc <= '0;
      a.rd_data <= RST_WORD;
      a.pt <= '0;
    end else begin
      er_st <= next_er_st;
      er_cnt <= next_er_cnt;
      a.acc <= next_acc;
      a.rd_data <= next_rd;
      a.pt <= next_pt;
    end
  end

  assign a.busy = (er_st == ER_RUN);
endmodule : pldmc_array

// ==== src/pldmc_core.sv ====
// eight-cell programmable logic core with mode, polarity, preload,
// signature, checksum, read protection and power-down
// assumes ref_clk at 200 MHz; all pins asynchronous to ref_clk
//
// Contract
// - The 64-bit user signature is readable at all times, protected or not.
// - The checksum covers the signature, so any signature change alters it.
// - Once protected, configuration readback returns zero until reprogram.
// - Programming erases the configuration itself with no separate step.
// - Each registered output can be forced high or low synchronously.
// - An open input or undriven I/O pin is seen as logic one; the clock edge and OE logic read ded_s without ded_open_s.
// - Power-up clears every register to low within one microsecond.
// - After power-up an enabled registered pin reads high for any polarity.
// - Two global bits select simple, complex or registered mode for all.
// - Each cell has a polarity bit that acts in every mode.
// - Each cell has an I/O select bit; configuration is 2 + 16 bits.
// - A dedicated power-down pin puts the core in standby.
// - The AND array takes up to 19 inputs into product terms.
// - Registered mode shares one clock and one OE pin; 8 or 7 terms.
// - Complex cells use 7 terms with one term as OE; simple drives unless its I/O select bit is set.
`timescale 1ns/100ps
module pldmc_core
  import pldmc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // dedicated input pins and their open flags
  input wire logic [10:0] ded_in,
  input wire logic [10:0] ded_open,
  // macrocell I/O pins
  input wire logic [7:0] io_in,
  input wire logic [7:0] io_open,
  output logic [7:0] io_out,
  output logic [7:0] io_oe_n,
  // standby
  input wire logic power_down_pin
);
  pldmc_arr_if a ();

  pldmc_array u_array (
    .ref_clk(ref_clk),
    .rst(rst),
    .a(a)
  );

  // pin synchronisers
  logic [38:0] s1, s2, next_s1, next_s2;
  logic [10:0] ded_s, ded_open_s;
  logic [7:0] io_in_s, io_open_s;
  logic pdown;

  always_comb begin
    next_s1 = {power_down_pin, io_open, io_in, ded_open, ded_in};
    next_s2 = s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
    end
  end

  assign ded_s = s2[10:0];
  assign ded_open_s = s2[21:11];
  assign io_in_s = s2[29:22];
  assign io_open_s = s2[37:30];
  assign pdown = s2[38];

  // register file and bus slave
  logic global_mode_select_a, global_mode_select_b, secure;
  logic next_mode_a, next_mode_b, next_secure;
  logic [7:0] pol, next_pol, cell_io_config_bit, next_io_cfg;
  logic [31:0] sig_lo, sig_hi, next_sig_lo, next_sig_hi;
  logic [31:0] csum, next_csum, next_readdata, wd;
  logic [6:0] arr_idx, next_arr_idx;
  logic [31:0] arr_wdata, next_arr_wdata;
  logic arr_wr, next_arr_wr, erase, next_erase;
  logic preload_go, next_preload_go;
  logic [7:0] preload_val, next_preload_val;
  logic [1:0] stale, next_stale;
  logic next_waitrequest, bus_req, bus_acc, arr_reg;
  logic [7:0] q, next_q;
  logic [7:0] pwr_cnt, next_pwr_cnt;
  logic pwr_done;
  pldmc_mode_e mode;
  logic [1:0] mode_vis;

  assign pwr_done = (pwr_cnt == PWRUP_CNT);
  // two global bits pick the mode
  assign mode = pldmc_mode_of(global_mode_select_a, global_mode_select_b);
  assign mode_vis = secure ? 2'b00
                           : {global_mode_select_b, global_mode_select_a};

  always_comb begin
    next_mode_a = global_mode_select_a;
    next_mode_b = global_mode_select_b;
    next_secure = secure;
    next_pol = pol;
    next_io_cfg = cell_io_config_bit;
    next_sig_lo = sig_lo;
    next_sig_hi = sig_hi;
    next_arr_idx = arr_idx;
    next_arr_wdata = arr_wdata;
    next_arr_wr = 1'b0;
    next_erase = 1'b0;
    next_preload_go = 1'b0;
    next_preload_val = preload_val;
    next_readdata = avs_readdata;
    next_stale = (stale != 2'h0) ? 2'(stale - 2'h1) : 2'h0;
    bus_req = avs_read | avs_write;
    arr_reg = (avs_address == ADR_ARR_IDX) || (avs_address == ADR_ARR_DATA);
    bus_acc = bus_req && avs_waitrequest &&
              (!arr_reg || (!a.busy && stale == 2'h0 && !erase));
    next_waitrequest = !bus_acc;
    wd = RST_WORD;
    // signature and configuration folded into the checksum
    next_csum = a.acc[31:0] ^ {26'h000_0000, a.acc[37:32]} ^ sig_lo ^
                sig_hi ^ {14'h0000, cell_io_config_bit, pol,
                          global_mode_select_b, global_mode_select_a};
    if (bus_acc && avs_write) begin
      case (avs_address)
        ADR_CTRL: begin
          wd = pldmc_merge({28'h000_0000, 1'b0, secure, global_mode_select_b,
                            global_mode_select_a},
                           avs_writedata, avs_byteenable);
          next_mode_a = wd[CTRL_MODE_A];
          next_mode_b = wd[CTRL_MODE_B];
          next_secure = secure | wd[CTRL_SECURE];
          if (wd[CTRL_PROGRAM]) begin
            next_erase = 1'b1;
            next_mode_a = 1'b0;
            next_mode_b = 1'b0;
            // secure set in the same write survives the erase
            next_secure = wd[CTRL_SECURE];
            next_pol = RST_BYTE;
            next_io_cfg = RST_BYTE;
            next_sig_lo = RST_WORD;
            next_sig_hi = RST_WORD;
          end
        end
        ADR_CELL: begin
          // eight polarity and eight I/O select bits
          wd = pldmc_merge({16'h0000, cell_io_config_bit, pol},
                           avs_writedata, avs_byteenable);
          next_pol = wd[7:0];
          next_io_cfg = wd[15:8];
        end
        ADR_PRELOAD: begin
          next_preload_go = avs_byteenable[0];
          next_preload_val = avs_writedata[7:0];
        end
        ADR_SIG_LO: next_sig_lo = pldmc_merge(sig_lo, avs_writedata,
                                              avs_byteenable);
        ADR_SIG_HI: next_sig_hi = pldmc_merge(sig_hi, avs_writedata,
                                              avs_byteenable);
        ADR_ARR_IDX: begin
          next_arr_idx = avs_writedata[6:0];
          next_stale = ARR_STALE;
        end
        ADR_ARR_DATA: begin
          next_arr_wr = 1'b1;
          next_arr_wdata = avs_writedata;
          next_stale = ARR_STALE;
        end
        default: wd = RST_WORD;
      endcase
    end
    if (bus_acc && avs_read) begin
      case (avs_address)
        ADR_CTRL: next_readdata = {29'h0000_0000, secure, mode_vis};
        ADR_CELL: next_readdata = secure ? RST_WORD
                    : {16'h0000, cell_io_config_bit, pol};
        ADR_PRELOAD: next_readdata = {24'h00_0000, q};
        ADR_STATUS: next_readdata = {26'h000_0000, pwr_done, pdown,
                                     a.busy, secure, mode_vis};
        ADR_SIG_LO: next_readdata = sig_lo;
        ADR_SIG_HI: next_readdata = sig_hi;
        ADR_CSUM: next_readdata = csum;
        ADR_ARR_IDX: next_readdata = {25'h000_0000, arr_idx};
        ADR_ARR_DATA: next_readdata = secure ? RST_WORD : a.rd_data;
        default: next_readdata = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_mode_select_a <= 1'b0;
      global_mode_select_b <= 1'b0;
      secure <= 1'b0;
      pol <= RST_BYTE;
      cell_io_config_bit <= RST_BYTE;
      sig_lo <= RST_WORD;
      sig_hi <= RST_WORD;
      csum <= RST_WORD;
      arr_idx <= 7'h00;
      arr_wdata <= RST_WORD;
      arr_wr <= 1'b0;
      erase <= 1'b0;
      preload_go <= 1'b0;
      preload_val <= RST_BYTE;
      stale <= 2'h0;
      avs_readdata <= RST_WORD;
      avs_waitrequest <= 1'b1;
    end else begin
      global_mode_select_a <= next_mode_a;
      global_mode_select_b <= next_mode_b;
      secure <= next_secure;
      pol <= next_pol;
      cell_io_config_bit <= next_io_cfg;
      sig_lo <= next_sig_lo;
      sig_hi <= next_sig_hi;
      csum <= next_csum;
      arr_idx <= next_arr_idx;
      arr_wdata <= next_arr_wdata;
      arr_wr <= next_arr_wr;
      erase <= next_erase;
      preload_go <= next_preload_go;
      preload_val <= next_preload_val;
      stale <= next_stale;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  assign a.wr = arr_wr;
  assign a.erase = erase;
  assign a.idx = arr_idx;
  assign a.wr_data = arr_wdata;

  // output logic cells
  logic [7:0] next_io_out, next_io_oe_n, io_pin, fb, sum8, sum7, oe_pt;
  logic clk_d, next_clk_d, clk_rise;

  always_comb begin
    next_q = q;
    next_pwr_cnt = pwr_cnt;
    next_io_out = io_out;
    next_io_oe_n = io_oe_n;
    // clock pin edge found after synchronising
    next_clk_d = ded_s[DED_CLK];
    clk_rise = ded_s[DED_CLK] && !clk_d;
    for (int i = 0; i < N_CELL; i++) begin
      io_pin[i] = io_oe_n[i] ? (io_in_s[i] | io_open_s[i]) : io_out[i];
      fb[i] = (mode == MODE_REGISTERED && !cell_io_config_bit[i]) ? q[i]
                                                                 : io_pin[i];
      sum8[i] = |a.pt[i*PT_CELL +: PT_CELL];
      sum7[i] = |a.pt[i*PT_CELL+1 +: PT_CELL-1];
      oe_pt[i] = a.pt[i*PT_CELL];
    end
    a.in_vec = {fb, ded_s | ded_open_s};
    if (!pwr_done) begin
      // registers held low for the power-up time
      next_pwr_cnt = 8'(pwr_cnt + 8'h01);
      next_q = RST_BYTE;
    end else if (preload_go) begin
      next_q = ~preload_val;
    end else if (!pdown && mode == MODE_REGISTERED && clk_rise) begin
      // one shared clock pin for all registers
      for (int i = 0; i < N_CELL; i++) begin
        if (!cell_io_config_bit[i]) begin
          next_q[i] = sum8[i] ^ pol[i];
        end
      end
    end
    if (!pdown) begin
      for (int i = 0; i < N_CELL; i++) begin
        case (mode)
          MODE_SIMPLE: begin
            // simple cells drive unless used as input
            next_io_out[i] = ~(sum8[i] ^ pol[i]);
            next_io_oe_n[i] = cell_io_config_bit[i];
          end
          MODE_COMPLEX: begin
            // seven terms plus an enable term
            next_io_out[i] = ~(sum7[i] ^ pol[i]);
            next_io_oe_n[i] = ~oe_pt[i];
          end
          MODE_REGISTERED: begin
            if (!cell_io_config_bit[i]) begin
              // cleared register shows high on the pin
              next_io_out[i] = ~next_q[i];
              next_io_oe_n[i] = ded_s[DED_OE];
            end else begin
              next_io_out[i] = ~(sum7[i] ^ pol[i]);
              next_io_oe_n[i] = ~oe_pt[i];
            end
          end
          default: begin
            next_io_out[i] = 1'b0;
            next_io_oe_n[i] = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= RST_BYTE;
      pwr_cnt <= RST_BYTE;
      clk_d <= 1'b0;
      io_out <= RST_BYTE;
      io_oe_n <= 8'hFF;
    end else begin
      q <= next_q;
      pwr_cnt <= next_pwr_cnt;
      clk_d <= next_clk_d;
      io_out <= next_io_out;
      io_oe_n <= next_io_oe_n;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sig_read_a: assert property (
    bus_acc && avs_read && avs_address == ADR_SIG_LO && secure
    |=> avs_readdata == $past(sig_lo)) else $error("signature hidden");
  csum_sig_a: assert property (
    sig_hi != $past(sig_hi) && sig_lo == $past(sig_lo) &&
    a.acc == $past(a.acc) && pol == $past(pol) &&
    cell_io_config_bit == $past(cell_io_config_bit) &&
    mode == $past(mode) |=> csum != $past(csum))
    else $error("checksum ignores signature");
  secure_hide_a: assert property (
    bus_acc && avs_read && avs_address == ADR_ARR_DATA && secure
    |=> avs_readdata == 32'h0000_0000) else $error("array read leaked");
  secure_keep_a: assert property (
    secure && !next_erase |=> secure) else $error("protection lost");
  erase_busy_a: assert property (
    erase |=> a.busy [*8]) else $error("erase not running");
  preload_a: assert property (
    preload_go && pwr_done |=> q == ~$past(preload_val))
    else $error("preload missed");
  pwrup_low_a: assert property (
    !pwr_done |=> q == 8'h00) else $error("register not cleared");
  pin_high_a: assert property (
    !pdown && mode == MODE_REGISTERED && !cell_io_config_bit[0]
    |=> io_out[0] == ~q[0]) else $error("pin not inverse of register");
  pdown_hold_a: assert property (
    pdown && $past(pdown) |=> $stable(io_out) && $stable(io_oe_n))
    else $error("standby not frozen");
  simple_oe_a: assert property (
    !pdown && mode == MODE_SIMPLE && !cell_io_config_bit[1]
    |=> !io_oe_n[1]) else $error("simple output off");
  reserved_off_a: assert property (
    !pdown && mode == MODE_RESERVED |=> io_oe_n == 8'hFF)
    else $error("reserved mode drives");

  erase_c: cover property (erase ##1 a.busy);
  preload_c: cover property (preload_go && pwr_done);
  reg_clk_c: cover property (clk_rise && mode == MODE_REGISTERED);
  secure_rd_c: cover property (bus_acc && avs_read && secure);
endmodule : pldmc_core

// ==== test/pldmc_board_model.sv ====
// board side of the pins: pads with pull-ups, levels from the bench
// assumes the bench pulses the shared clock pin level through ded_lvl
`timescale 1ns/100ps
module pldmc_board_model (
  // bench levels and float masks
  input wire logic [10:0] ded_lvl,
  input wire logic [10:0] ded_float,
  input wire logic [7:0] pad_lvl,
  input wire logic [7:0] pad_float,
  // core pin side
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe_n,
  output logic [10:0] ded_in,
  output logic [10:0] ded_open,
  output logic [7:0] io_in,
  output logic [7:0] io_open
);
  assign ded_in = ded_lvl | ded_float;
  assign ded_open = ded_float;
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & (pad_lvl | pad_float));
  assign io_open = pad_float;
endmodule : pldmc_board_model

// ==== test/tb.sv ====
// self-checking bench of the macrocell core over its register bus
// assumes the board model on the pins and a 200 MHz clock
`timescale 1ns/100ps
module tb;
  import pldmc_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
$display("ERROR %0t got %h exp %h", $time, a, b); end end
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, power_down_pin;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, c0, sig, seed_v;
  logic [3:0] avs_byteenable;
  logic [10:0] ded_in, ded_open, ded_lvl, ded_float;
  logic [7:0] io_in, io_open, io_out, io_oe_n, pad_lvl, pad_float, pv, pol;
  int n_errors = 0;
  int num_checks = 0;
  pldmc_core dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ded_in(ded_in), .ded_open(ded_open), .io_in(io_in), .io_open(io_open),
    .io_out(io_out), .io_oe_n(io_oe_n), .power_down_pin(power_down_pin));
  pldmc_board_model board_u (.ded_lvl(ded_lvl), .ded_float(ded_float),
    .pad_lvl(pad_lvl), .pad_float(pad_float), .io_out(io_out),
    .io_oe_n(io_oe_n), .ded_in(ded_in), .ded_open(ded_open), .io_in(io_in),
    .io_open(io_open));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // expected status low bits: mode hidden while protected
  function automatic logic [2:0] st_exp(input logic [1:0] m, input logic s);
    return s ? 3'b100 : {1'b0, m};
  endfunction : st_exp
  // pins when only cell 0 has a live term, following one input
  function automatic logic [7:0] pin_exp(input logic t, input logic [7:0] p);
    return ~({7'h00, t} ^ p);
  endfunction : pin_exp
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) begin
      `CHK(1'b0, 1'b1)
      close_out;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
    while (q[b] !== v && n < 300) begin
      bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
      n++;
    end
    `CHK(q[b], v)
  endtask : wait_st
  task close_out;
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, power_down_pin} = 3'h0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    seed_v = $urandom(32'hc260);
    ded_lvl = 11'h000;
    ded_float = 11'h000;
    pad_lvl = 8'($urandom);
    pad_float = 8'($urandom);
    repeat (8) @(posedge ref_clk);
    `CHK(io_oe_n, 8'hFF)
    `CHK(avs_waitrequest, 1'b1)
    rst <= 1'b0;
    ded_lvl <= {9'($urandom), 2'h0};
    @(posedge ref_clk);
    wait_st(ST_READY, 1'b1);
    wait_st(ST_BUSY, 1'b0);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADR_CTRL, 32'(m), 4'hF);
      bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
      `CHK(q[2:0], st_exp(2'(m), 1'b0))
    end
    bus(1'b0, ADR_CSUM, 32'h0, 4'hF);
    c0 = q;
    sig = $urandom | 32'h1;
    bus(1'b1, ADR_SIG_LO, sig, 4'hF);
    bus(1'b1, ADR_SIG_HI, ~sig, 4'hF);
    bus(1'b0, ADR_SIG_HI, 32'h0, 4'hF);
    `CHK(q, ~sig)
    bus(1'b0, ADR_CSUM, 32'h0, 4'hF);
    `CHK(q !== c0, 1'b1)
    pol = 8'($urandom);
    bus(1'b1, ADR_CELL, {16'h0, ~pol, pol}, 4'hF);
    bus(1'b0, ADR_CELL, 32'h0, 4'hF);
    `CHK(q[15:0], {~pol, pol})
    bus(1'b1, ADR_CTRL, 32'h5, 4'hF);
    bus(1'b1, ADR_CTRL, 32'h0, 4'hF);
    bus(1'b0, ADR_CELL, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    // erased term would read all ones if not hidden
    bus(1'b0, ADR_ARR_DATA, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
    `CHK(q[2:0], st_exp(2'h0, 1'b1))
    bus(1'b0, ADR_SIG_LO, 32'h0, 4'hF);
    `CHK(q, sig)
    bus(1'b1, ADR_CTRL, 32'h8, 4'hF);
    wait_st(ST_BUSY, 1'b0);
    `CHK(q[2:0], 3'h0)
    bus(1'b0, ADR_SIG_LO, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    foreach (pv[i]) begin
      pol = (i == 0) ? 8'hFF : 8'($urandom);
      bus(1'b1, ADR_CTRL, 32'h8, 4'hF);
      wait_st(ST_BUSY, 1'b0);
      bus(1'b1, ADR_CELL, {24'h0, pol}, 4'hF);
      bus(1'b1, ADR_CTRL, 32'h2, 4'hF);
      repeat (6) @(posedge ref_clk);
      `CHK(io_out, 8'hFF)
      `CHK(io_oe_n, 8'h00)
      if (i < 2) begin
        pv = (i == 0) ? 8'h00 : 8'($urandom);
        bus(1'b1, ADR_PRELOAD, {24'h0, pv}, 4'h1);
        repeat (4) @(posedge ref_clk);
        `CHK(io_out, pv)
        // back to cleared registers; programming leaves them alone
        bus(1'b1, ADR_PRELOAD, 32'hFF, 4'h1);
      end
    end
    bus(1'b1, ADR_CTRL, 32'h0, 4'hF);
    repeat (6) @(posedge ref_clk);
    `CHK(io_oe_n, 8'h00)
    `CHK(io_out, ~pol)
    // term 0 of cell 0 follows dedicated pin 2 only
    bus(1'b1, ADR_ARR_IDX, 32'h0, 4'hF);
    bus(1'b1, ADR_ARR_DATA, 32'h4, 4'hF);
    bus(1'b1, ADR_ARR_IDX, 32'h1, 4'hF);
    bus(1'b1, ADR_ARR_DATA, 32'h0, 4'hF);
    repeat (2) begin
      repeat (6) @(posedge ref_clk);
      `CHK(io_out, pin_exp(ded_lvl[2], pol))
      ded_lvl[2] <= ~ded_lvl[2];
    end
    bus(1'b1, ADR_CTRL, 32'h1, 4'hF);
    repeat (6) @(posedge ref_clk);
    `CHK(io_oe_n, ~{7'h00, ded_lvl[2]})
    `CHK(io_out, ~pol)
    bus(1'b1, ADR_ARR_IDX, 32'h0, 4'hF);
    bus(1'b0, ADR_ARR_DATA, 32'h0, 4'hF);
    `CHK(q, 32'h4)
    bus(1'b1, ADR_CTRL, 32'h2, 4'hF);
    // one pulse on the shared clock pin
    ded_lvl[DED_CLK] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ded_lvl[DED_CLK] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(io_out, pin_exp(ded_lvl[2], pol))
    ded_lvl[DED_OE] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK(io_oe_n, 8'hFF)
    ded_lvl[DED_OE] <= 1'b0;
    bus(1'b1, ADR_CTRL, 32'h3, 4'hF);
    repeat (6) @(posedge ref_clk);
    `CHK(io_oe_n, 8'hFF)
    power_down_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
    `CHK(q[ST_PDOWN], 1'b1)
    bus(1'b0, 6'h3C, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    close_out;
  end
endmodule : tb
